/* design/fcm_config_bank.sv */
// Fan unit configuration register bank with AXI4-Lite slave
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module fcm_config_bank
   import fcm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // AXI4-Lite write address and data
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Fan configuration outputs
   output fcm_fan_cfg_t fanCfg,
   output logic deviceActive,
   output logic outputsFloat,
   output logic [15:0] runtimeBase
);

   // Register storage
   logic [7:0] activateReg;
   logic [7:0] baseHighReg;
   logic [7:0] baseLowReg;
   logic [7:0] intSelectReg;
   logic [7:0] intTypeReg;
   logic [7:0] fanCfg1Reg;
   logic [7:0] fanCfg2Reg;
   logic [7:0] globalCfgReg;
   // Write channel capture
   logic awHeld;
   logic wHeld;
   logic [7:0] wIndexReg;
   logic [7:0] wDataReg;
   logic wLaneReg;
   fcm_wstate_t wState;
   logic doWrite;
   logic [7:0] rdByte;
   logic rdHit;

   // Index decode from a byte address; the low two address bits are ignored
   function automatic logic [7:0] toIndex(input logic [9:0] addr);
      toIndex = addr[9:2];
   endfunction

   // Known index check for the write path; the read path decodes its own hit
   function automatic logic isMapped(input logic [7:0] idx);
      case (idx)
         IDX_ACTIVATE, IDX_BASE_HIGH, IDX_BASE_LOW, IDX_INT_SELECT, IDX_INT_TYPE,
         IDX_DMA_REPORT0, IDX_DMA_REPORT1, IDX_FAN_CFG1, IDX_FAN_CFG2,
         IDX_GLOBAL_CFG: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction

   // Address and data may arrive in either order
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         wIndexReg <= RST_ZERO;
         wDataReg <= RST_ZERO;
         wLaneReg <= 1'b0;
      end else if (wState == W_IDLE) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            wIndexReg <= toIndex(s_axi_awaddr);
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wDataReg <= s_axi_wdata[7:0];
            wLaneReg <= s_axi_wstrb[0];
         end
      end else begin
         // Cleared once the write is committed
         awHeld <= 1'b0;
         wHeld <= 1'b0;
      end
   end

   // Ready only while the half is still missing
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= (wState == W_IDLE) && !awHeld && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= (wState == W_IDLE) && !wHeld && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // Commit fires in the same cycle that both halves are held
   assign doWrite = (wState == W_IDLE) && awHeld && wHeld;

   // Write response sequencing
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wState <= W_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         case (wState)
            W_IDLE: begin
               if (doWrite) begin
                  wState <= W_RESP;
                  s_axi_bvalid <= 1'b1;
                  // Unmapped index answers an error, nothing stored
                  s_axi_bresp <= isMapped(wIndexReg) ? RESP_OKAY : RESP_SLVERR;
               end
            end
            W_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wState <= W_HOLD;
               end
            end
            W_HOLD: begin
               // One idle cycle lets ready flags recompute
               wState <= W_IDLE;
            end
            default: begin
               wState <= W_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // Device-level registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         activateReg <= RST_ZERO;
         baseHighReg <= RST_ZERO;
         baseLowReg <= RST_ZERO;
         intSelectReg <= RST_ZERO;
         intTypeReg <= RST_INT_TYPE;
         globalCfgReg <= RST_ZERO;
      end else if (doWrite && wLaneReg) begin
         case (wIndexReg)
            IDX_ACTIVATE: activateReg <= wDataReg;
            IDX_BASE_HIGH: baseHighReg <= wDataReg;
            // Low nibble never stored, reads zero
            IDX_BASE_LOW: baseLowReg <= wDataReg & MASK_BASE_LOW;
            IDX_INT_SELECT: intSelectReg <= wDataReg;
            // Only bit 1 follows writes
            IDX_INT_TYPE: intTypeReg <= (intTypeReg & ~MASK_INT_TYPE)
               | (wDataReg & MASK_INT_TYPE);
            IDX_GLOBAL_CFG: globalCfgReg <= wDataReg;
            default: begin
            end
         endcase
      end
   end

   // Fan configuration registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fanCfg1Reg <= RST_ZERO;
         fanCfg2Reg <= RST_ZERO;
      end else if (doWrite && wLaneReg) begin
         // Reserved bits masked off so they read zero
         if (wIndexReg == IDX_FAN_CFG1) begin
            fanCfg1Reg <= wDataReg & MASK_FAN_CFG1;
         end
         if (wIndexReg == IDX_FAN_CFG2) begin
            fanCfg2Reg <= wDataReg & MASK_FAN_CFG2;
         end
      end
   end

   // Read data mux; DMA report is a constant, not storage
   always_comb begin
      rdByte = RST_ZERO;
      rdHit = 1'b1;
      case (toIndex(s_axi_araddr))
         IDX_ACTIVATE: rdByte = activateReg;
         IDX_BASE_HIGH: rdByte = baseHighReg;
         IDX_BASE_LOW: rdByte = baseLowReg;
         IDX_INT_SELECT: rdByte = intSelectReg;
         IDX_INT_TYPE: rdByte = intTypeReg;
         IDX_DMA_REPORT0: rdByte = VAL_NO_DMA;
         IDX_DMA_REPORT1: rdByte = VAL_NO_DMA;
         IDX_FAN_CFG1: rdByte = fanCfg1Reg;
         IDX_FAN_CFG2: rdByte = fanCfg2Reg;
         IDX_GLOBAL_CFG: rdByte = globalCfgReg;
         default: rdHit = 1'b0;
      endcase
   end

   // Read channel: address taken, data one cycle later
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rdByte};
         s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // Fan enables and pin float control from registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fanCfg <= '0;
         deviceActive <= 1'b0;
         outputsFloat <= 1'b0;
         runtimeBase <= 16'h0000;
      end else begin
         fanCfg.monitorEn[0] <= fanCfg1Reg[POS_MON0];
         fanCfg.controlEn[0] <= fanCfg1Reg[POS_CTL0];
         fanCfg.invertEn[0] <= fanCfg1Reg[POS_INV0];
         fanCfg.monitorEn[1] <= fanCfg1Reg[POS_MON1];
         fanCfg.controlEn[1] <= fanCfg1Reg[POS_CTL1];
         fanCfg.invertEn[1] <= fanCfg1Reg[POS_INV1];
         fanCfg.monitorEn[2] <= fanCfg2Reg[POS_MON2];
         fanCfg.controlEn[2] <= fanCfg2Reg[POS_CTL2];
         fanCfg.invertEn[2] <= fanCfg2Reg[POS_INV2];
         // Active only when both activate bits are set
         deviceActive <= activateReg[POS_ACTIVE] && globalCfgReg[POS_ACTIVE];
         outputsFloat <= fanCfg1Reg[POS_TRISTATE]
            && !(activateReg[POS_ACTIVE] && globalCfgReg[POS_ACTIVE]);
         // Low nibble always zero keeps the window aligned
         runtimeBase <= {baseHighReg, baseLowReg[7:RT_OFFSET_BITS],
            {RT_OFFSET_BITS{1'b0}}};
      end
   end

   // Checks on the stored and exported state
   // Fixed low nibble of the base low byte
   a_base_low_nibble: assert property (@(posedge sys_clk) disable iff (rst)
      baseLowReg[3:0] == 4'h0)
      else $error("base low nibble not zero");
   // Upper nibble of the base low byte follows a full-lane write
   a_base_low_write: assert property (@(posedge sys_clk) disable iff (rst)
      doWrite && wLaneReg && wIndexReg == IDX_BASE_LOW
      |=> baseLowReg[7:4] == $past(wDataReg[7:4]))
      else $error("base low upper bits not stored");
   // Exported base keeps the window aligned
   a_runtime_aligned: assert property (@(posedge sys_clk) disable iff (rst)
      runtimeBase[3:0] == 4'h0)
      else $error("runtime base misaligned");
   // Exported base tracks both base bytes one cycle late
   a_runtime_follow: assert property (@(posedge sys_clk) disable iff (rst)
      ##1 (runtimeBase[15:8] == $past(baseHighReg)
      && runtimeBase[7:4] == $past(baseLowReg[7:4])))
      else $error("runtime base not following registers");
   // Interrupt type keeps its read-only bits at their reset value
   a_int_type_fixed: assert property (@(posedge sys_clk) disable iff (rst)
      (intTypeReg & ~MASK_INT_TYPE) == (RST_INT_TYPE & ~MASK_INT_TYPE))
      else $error("interrupt type read-only bits moved");
   // Writable interrupt type bit follows a full-lane write
   a_int_type_write: assert property (@(posedge sys_clk) disable iff (rst)
      doWrite && wLaneReg && wIndexReg == IDX_INT_TYPE
      |=> intTypeReg[1] == $past(wDataReg[1]))
      else $error("interrupt type bit 1 not stored");
   // Interrupt select holds the whole written byte
   a_int_select_write: assert property (@(posedge sys_clk) disable iff (rst)
      doWrite && wLaneReg && wIndexReg == IDX_INT_SELECT
      |=> intSelectReg == $past(wDataReg))
      else $error("interrupt select not stored");
   // Reserved fan bits never hold a one
   a_fan_reserved: assert property (@(posedge sys_clk) disable iff (rst)
      fanCfg1Reg[1] == 1'b0 && fanCfg2Reg[7:3] == 5'h00)
      else $error("fan reserved bits set");
   // First fan register stores only its defined bits
   a_fan_cfg1_write: assert property (@(posedge sys_clk) disable iff (rst)
      doWrite && wLaneReg && wIndexReg == IDX_FAN_CFG1
      |=> fanCfg1Reg == $past(wDataReg & MASK_FAN_CFG1))
      else $error("first fan register not stored");
   // Second fan register stores only its defined bits
   a_fan_cfg2_write: assert property (@(posedge sys_clk) disable iff (rst)
      doWrite && wLaneReg && wIndexReg == IDX_FAN_CFG2
      |=> fanCfg2Reg == $past(wDataReg & MASK_FAN_CFG2))
      else $error("second fan register not stored");
   // Float request while inactive must reach the pins
   a_float_follow: assert property (@(posedge sys_clk) disable iff (rst)
      fanCfg1Reg[POS_TRISTATE] && !activateReg[POS_ACTIVE] |=> outputsFloat)
      else $error("outputs not floated while inactive");
   // An active unit or a clear float bit keeps the pins driven
   a_float_driven: assert property (@(posedge sys_clk) disable iff (rst)
      !fanCfg1Reg[POS_TRISTATE] || (activateReg[POS_ACTIVE] && globalCfgReg[POS_ACTIVE])
      |=> !outputsFloat)
      else $error("outputs floated while active or float off");
   // Activation needs both activate bits
   a_active_both: assert property (@(posedge sys_clk) disable iff (rst)
      ##1 deviceActive == $past(activateReg[POS_ACTIVE] && globalCfgReg[POS_ACTIVE]))
      else $error("device active state wrong");
   // Fan 0 enables follow the first register one cycle late
   a_fan0_enables: assert property (@(posedge sys_clk) disable iff (rst)
      $changed(fanCfg1Reg) |=> fanCfg.monitorEn[0] == $past(fanCfg1Reg[POS_MON0])
      && fanCfg.controlEn[0] == $past(fanCfg1Reg[POS_CTL0])
      && fanCfg.invertEn[0] == $past(fanCfg1Reg[POS_INV0]))
      else $error("fan 0 enables wrong");
   // Fan 1 enables follow the first register one cycle late
   a_fan1_enables: assert property (@(posedge sys_clk) disable iff (rst)
      ##1 fanCfg.monitorEn[1] == $past(fanCfg1Reg[POS_MON1])
      && fanCfg.controlEn[1] == $past(fanCfg1Reg[POS_CTL1])
      && fanCfg.invertEn[1] == $past(fanCfg1Reg[POS_INV1]))
      else $error("fan 1 enables wrong");
   // Fan 2 enables follow the second register one cycle late
   a_fan2_enables: assert property (@(posedge sys_clk) disable iff (rst)
      ##1 fanCfg.monitorEn[2] == $past(fanCfg2Reg[POS_MON2])
      && fanCfg.controlEn[2] == $past(fanCfg2Reg[POS_CTL2])
      && fanCfg.invertEn[2] == $past(fanCfg2Reg[POS_INV2]))
      else $error("fan 2 enables wrong");
   // First report register answers the no-channel code
   a_dma_report: assert property (@(posedge sys_clk) disable iff (rst)
      s_axi_arvalid && s_axi_arready && toIndex(s_axi_araddr) == IDX_DMA_REPORT0
      |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, VAL_NO_DMA})
      else $error("dma report value wrong");
   // Second report register answers the same code
   a_dma_report1: assert property (@(posedge sys_clk) disable iff (rst)
      s_axi_arvalid && s_axi_arready && toIndex(s_axi_araddr) == IDX_DMA_REPORT1
      |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, VAL_NO_DMA})
      else $error("second dma report value wrong");
   // Every committed write is answered
   a_write_resp: assert property (@(posedge sys_clk) disable iff (rst)
      doWrite |=> s_axi_bvalid)
      else $error("write response missing");
   // Reset values, seen the cycle after any edge with reset high
   a_fan_cfg_reset: assert property (@(posedge sys_clk)
      rst |=> fanCfg1Reg == RST_ZERO && fanCfg2Reg == RST_ZERO && fanCfg == '0)
      else $error("fan registers not cleared by reset");
   a_activate_reset: assert property (@(posedge sys_clk)
      rst |=> activateReg == RST_ZERO && !deviceActive)
      else $error("activate register not cleared by reset");
   a_base_reset: assert property (@(posedge sys_clk)
      rst |=> baseHighReg == RST_ZERO && baseLowReg == RST_ZERO && runtimeBase == 16'h0000)
      else $error("base registers not cleared by reset");
   a_int_select_reset: assert property (@(posedge sys_clk)
      rst |=> intSelectReg == RST_ZERO)
      else $error("interrupt select not cleared by reset");
   a_int_type_reset: assert property (@(posedge sys_clk)
      rst |=> intTypeReg == RST_INT_TYPE)
      else $error("interrupt type not at reset value");

endmodule // fcm_config_bank

/* design/fcm_pkg.sv */
// Package for the fan unit configuration register bank
package fcm_pkg;
   // Register indexes, byte address is four times the index
   localparam logic [7:0] IDX_ACTIVATE = 8'h30;
   localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
   localparam logic [7:0] IDX_BASE_LOW = 8'h61;
   localparam logic [7:0] IDX_INT_SELECT = 8'h70;
   localparam logic [7:0] IDX_INT_TYPE = 8'h71;
   localparam logic [7:0] IDX_DMA_REPORT0 = 8'h74;
   localparam logic [7:0] IDX_DMA_REPORT1 = 8'h75;
   localparam logic [7:0] IDX_FAN_CFG1 = 8'hF0;
   localparam logic [7:0] IDX_FAN_CFG2 = 8'hF1;
   localparam logic [7:0] IDX_GLOBAL_CFG = 8'hF8;
   // Reset values and the fixed DMA report value
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_INT_TYPE = 8'h03;
   localparam logic [7:0] VAL_NO_DMA = 8'h04;
   // Writable masks
   localparam logic [7:0] MASK_BASE_LOW = 8'hF0;
   localparam logic [7:0] MASK_INT_TYPE = 8'h02;
   localparam logic [7:0] MASK_FAN_CFG1 = 8'hFD;
   localparam logic [7:0] MASK_FAN_CFG2 = 8'h07;
   // Field positions
   localparam int POS_TRISTATE = 0;
   localparam int POS_MON0 = 2;
   localparam int POS_CTL0 = 3;
   localparam int POS_INV0 = 4;
   localparam int POS_MON1 = 5;
   localparam int POS_CTL1 = 6;
   localparam int POS_INV1 = 7;
   localparam int POS_MON2 = 0;
   localparam int POS_CTL2 = 1;
   localparam int POS_INV2 = 2;
   localparam int POS_ACTIVE = 0;
   // Runtime window: 16 bytes, low four address bits select
   localparam int RT_OFFSET_BITS = 4;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Per fan enables
   typedef struct packed {
      logic [2:0] monitorEn;
      logic [2:0] controlEn;
      logic [2:0] invertEn;
   } fcm_fan_cfg_t;
   // Write channel states
   typedef enum logic [2:0] {
      W_IDLE = 3'b001,
      W_RESP = 3'b010,
      W_HOLD = 3'b100
   } fcm_wstate_t;
endpackage

/* dv/fcm_fan_model.sv */
// Behavioural fan set that spins fans whose speed control is enabled while the drive is not floated
`timescale 1ns/1ns
module fcm_fan_model
   import fcm_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Configuration seen by the fans
   input wire fcm_fan_cfg_t fanCfg,
   input wire logic outputsFloat,
   // Tachometer pulses back from each fan
   output logic [2:0] tachPulse
);
   // Known start so the toggle below never runs from an unknown
   initial tachPulse = 3'h0;
   // Floating drive leaves a fan coasting, so its tach stays low
   always @(posedge sys_clk) begin
      tachPulse <= fanCfg.controlEn & {3{~outputsFloat}} & ~tachPulse;
   end
endmodule // fcm_fan_model

/* dv/fan_control_monitor_config_tb.sv */
// Self-checking bench for the fan unit configuration register bank
`timescale 1ns/1ns
module fan_control_monitor_config_tb
   import fcm_pkg::*;
;
   // Clock, reset and AXI4-Lite master side
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   // Design outputs
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   fcm_fan_cfg_t fanCfg;
   logic deviceActive, outputsFloat;
   logic [15:0] runtimeBase;
   logic [2:0] tachPulse;
   // Score and hang guard
   int mismatches = 0, compares = 0, cycles = 0;

   // 25 MHz clock
   always #20 sys_clk = ~sys_clk;

   fcm_config_bank dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fanCfg, .deviceActive, .outputsFloat,
      .runtimeBase);
   fcm_fan_model fans (.sys_clk, .fanCfg, .outputsFloat, .tachPulse);

   // Compare and count
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One write, address and data offered together, each released when taken
   task automatic axi_write(input logic [7:0] idx, input logic [7:0] data,
                            input logic [3:0] strb, output logic [1:0] resp);
      bit awDone, wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h00_0000, data};
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(awDone && wDone)) begin
         @(posedge sys_clk);
         if (!awDone && s_axi_awready) begin
            awDone = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wDone && s_axi_wready) begin
            wDone = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      // bready already high, so the edge showing bvalid is the handshake
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // One read, result taken at the handshake edge
   task automatic axi_read(input logic [7:0] idx, output logic [31:0] data,
                           output logic [1:0] resp);
      @(posedge sys_clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
      data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Full-lane write and checked read
   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      logic [1:0] resp;
      axi_write(idx, data, 4'hF, resp);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] data;
      logic [1:0] resp;
      axi_read(idx, data, resp);
      check($sformatf("reg %h", idx), data, {24'h00_0000, exp});
   endtask

   // Every register except the global configuration at its reset value
   task automatic test_reset_values();
      logic [7:0] idxs[9] = '{IDX_ACTIVATE, IDX_BASE_HIGH, IDX_BASE_LOW, IDX_INT_SELECT,
         IDX_INT_TYPE, IDX_DMA_REPORT0, IDX_DMA_REPORT1, IDX_FAN_CFG1, IDX_FAN_CFG2};
      logic [7:0] exps[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h04, 8'h04, 8'h00, 8'h00};
      for (int i = 0; i < 9; i++) rd(idxs[i], exps[i]);
      check("fanCfg", fanCfg, 9'h000);
      check("runtimeBase", runtimeBase, 16'h0000);
   endtask

   // Per-fan enables as seen at the outputs
   task automatic fans_are(input logic [2:0] mon, input logic [2:0] ctl, input logic [2:0] inv);
      check("monitorEn", fanCfg.monitorEn, mon);
      check("controlEn", fanCfg.controlEn, ctl);
      check("invertEn", fanCfg.invertEn, inv);
      check("tach idle fans", tachPulse & ~ctl, 3'b000);
   endtask

   // Complementary patterns catch swapped or shifted fields
   task automatic test_fan_bits();
      wr(IDX_FAN_CFG1, 8'h94);
      wr(IDX_FAN_CFG2, 8'h02);
      rd(IDX_FAN_CFG1, 8'h94);
      fans_are(3'b001, 3'b100, 3'b011);
      wr(IDX_FAN_CFG1, 8'h6A);
      wr(IDX_FAN_CFG2, 8'hFD);
      rd(IDX_FAN_CFG1, 8'h68);
      rd(IDX_FAN_CFG2, 8'h05);
      fans_are(3'b110, 3'b011, 3'b100);
   endtask

   // Base address with fixed low nibble, and a write with lane 0 off
   task automatic test_base();
      logic [1:0] resp;
      wr(IDX_BASE_HIGH, 8'hAB);
      wr(IDX_BASE_LOW, 8'hFF);
      rd(IDX_BASE_HIGH, 8'hAB);
      rd(IDX_BASE_LOW, 8'hF0);
      check("runtimeBase", runtimeBase, 16'hABF0);
      axi_write(IDX_BASE_HIGH, 8'h12, 4'hE, resp);
      check("bresp lane0 off", resp, RESP_OKAY);
      rd(IDX_BASE_HIGH, 8'hAB);
   endtask

   // Interrupt select, interrupt type and the fixed DMA reports
   task automatic test_interrupt();
      wr(IDX_INT_SELECT, 8'h5A);
      rd(IDX_INT_SELECT, 8'h5A);
      wr(IDX_INT_TYPE, 8'h00);
      rd(IDX_INT_TYPE, 8'h01);
      wr(IDX_INT_TYPE, 8'hFE);
      rd(IDX_INT_TYPE, 8'h03);
      wr(IDX_DMA_REPORT0, 8'h00);
      wr(IDX_DMA_REPORT1, 8'hFF);
      rd(IDX_DMA_REPORT0, 8'h04);
      rd(IDX_DMA_REPORT1, 8'h04);
   endtask

   // Float only while the float bit is set and the unit is inactive
   task automatic float_is(input logic act, input logic flt);
      @(posedge sys_clk);
      @(posedge sys_clk);
      check("deviceActive", deviceActive, act);
      check("outputsFloat", outputsFloat, flt);
      check("tach while floated", flt ? tachPulse : 3'b000, 3'b000);
   endtask
   // Fan 0 control is on until the last step so a floated drive shows at its tach
   task automatic test_activation();
      wr(IDX_FAN_CFG1, 8'h09);
      float_is(1'b0, 1'b1);
      wr(IDX_ACTIVATE, 8'h01);
      float_is(1'b0, 1'b1);
      wr(IDX_GLOBAL_CFG, 8'h01);
      float_is(1'b1, 1'b0);
      wr(IDX_ACTIVATE, 8'h00);
      float_is(1'b0, 1'b1);
      wr(IDX_FAN_CFG1, 8'h00);
      float_is(1'b0, 1'b0);
   endtask

   // Unmapped index answers with an error on read and on write
   task automatic test_unmapped();
      logic [31:0] data;
      logic [1:0] resp;
      axi_read(8'h31, data, resp);
      check("rresp unmapped", resp, RESP_SLVERR);
      check("rdata unmapped", data, 32'h0000_0000);
      axi_write(8'h62, 8'hFF, 4'hF, resp);
      check("bresp unmapped", resp, RESP_SLVERR);
   endtask

   // Verdict and end of run
   task automatic print_verdict();
      if (mismatches == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         print_verdict();
      end
   end

   // Main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      test_reset_values();
      test_fan_bits();
      test_base();
      test_interrupt();
      test_activation();
      test_unmapped();
      print_verdict();
   end
endmodule // fan_control_monitor_config_tb
